//--- rtl/ufc_flow_char.v
// Character recognition and in-band flow control status for one UART channel
`timescale 1ns/10ps
`default_nettype none

`include "ufc_defines.vh"

// Notes on behaviour
// - Free transmit queue count reads 1..255, zero code means 256 when ready.
// - Xon compare character register, resets to 0x11.
// - Xoff compare character register, resets to 0x13.
// - Wake-up address compare character register, resets to 0x00.
// - Reading flow status clears its upper four bits.
// - Bits 7:6 record Xon/Xoff received, held until status read.
// - Received field updates on any match whatever modes or mask say.
// - Bits 5:4 record flow characters sent automatically: 01 Xon, 10 Xoff.
// - Bits 5:4 read 00 while automatic receiver flow mode is off.
// - Halt pending stops after current character, then shows halted.
// - Restarted transmitter shows re-enabled until status read returns normal.
// - Flow field shows 11 while stopped by own receiver's Xoff.
// - Character type bits 1:0 read 00 unless an automatic control is on.
// - Type 01 waits for queue data one bit time after flow char.
// - Type 10 pending Xoff, 11 pending Xon, each within one character time.
// - Recognition enable holds disable/enable pairs; zero bits do nothing.
// - Enable and disable both set for a function disables it.
// - Register-enabled recognition only reports events, no flow or wake actions.
// - Watchdog enable pair acts on the same bit as the control copy.
// - Enabled watchdog signals after 64 idle receiver bit times.
// - Flow interrupt mask lets Xon/Xoff recognition raise an interrupt.
module ufc_flow_char (
  input  wire        ref_clk,
  input  wire        nrst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Receiver side
  input  wire        bit_tick,
  input  wire        rx_idle,
  input  wire        rx_char_valid,
  input  wire [7:0]  rx_char,
  input  wire [1:0]  char_len,
  input  wire        rx_fill_high,
  input  wire        rx_fill_low,
  // Transmitter side
  input  wire [8:0]  tx_queue_count,
  input  wire        tx_busy,
  input  wire        tx_char_done,
  input  wire        flow_send_ack,
  output reg         flow_send_req,
  output reg  [7:0]  flow_send_char,
  output wire        tx_halt,
  output wire        transmit_ready_flag,
  // Events towards interrupt status
  output reg         on_char_event,
  output reg         off_char_event,
  output reg         wake_addr_event,
  output reg         flow_irq_event,
  output wire        watchdog_event
);

  // ------------------------------
  // State codes of the transmitter flow field
  // ------------------------------
  localparam [3:0] TXF_NORM = 4'b0001;
  localparam [3:0] TXF_PEND = 4'b0010;
  localparam [3:0] TXF_REEN = 4'b0100;
  localparam [3:0] TXF_HALT = 4'b1000;

  reg  [7:0]  flow_on_char_q;
  reg  [7:0]  flow_off_char_q;
  reg  [7:0]  wake_address_char_q;
  reg  [1:0]  rx_field_q;
  reg  [1:0]  atx_field_q;
  reg  [3:0]  txf_state_q;
  reg  [3:0]  txf_state_d;
  reg  [1:0]  txc_field_q;
  reg         rec_on_en_q;
  reg         rec_off_en_q;
  reg         rec_addr_en_q;
  reg         wd_en_q;
  reg         auto_tx_q;
  reg         auto_rx_q;
  reg         flow_mask_q;
  reg         off_sent_q;
  reg         sending_flow_q;
  reg  [7:0]  rd_status_q;
  reg  [1:0]  txf_code;
  reg  [31:0] rd_mux;
  reg         addr_ok;
  wire [7:0]  char_mask;
  wire [8:0]  free_full;
  wire        on_match;
  wire        off_match;
  wire        addr_match;
  wire        setup_ph;
  wire        access_ph;
  wire        wr_en;
  wire        status_rd;
  wire        any_auto;
  wire [7:0]  status_word;

  // ------------------------------
  // APB decode
  // ------------------------------
  // Zero wait states: read data is latched in the setup cycle
  assign pready    = 1'b1;
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_en     = access_ph && pwrite && addr_ok;
  assign status_rd = access_ph && !pwrite && (paddr == `UFC_OFS_STATUS);
  assign pslverr   = access_ph && !addr_ok;

  // Address check for unmapped accesses
  always @* begin
    case (paddr)
      `UFC_OFS_FREE_COUNT, `UFC_OFS_ON_CHAR, `UFC_OFS_OFF_CHAR, `UFC_OFS_WAKE_CHAR,
      `UFC_OFS_STATUS, `UFC_OFS_RECOG_EN, `UFC_OFS_CTRL: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ------------------------------
  // Free transmit queue count
  // ------------------------------
  // 256 free wraps to code zero; the ready flag tells it apart from full
  assign free_full           = `UFC_QUEUE_DEPTH - tx_queue_count;
  assign transmit_ready_flag = (free_full != 9'd0);

  // ------------------------------
  // Character compare
  // ------------------------------
  // Bits above the configured length are ignored on both sides
  assign char_mask  = 8'hFF >> (2'd3 - char_len);
  assign on_match   = rx_char_valid && ((rx_char & char_mask) == (flow_on_char_q & char_mask));
  assign off_match  = rx_char_valid && ((rx_char & char_mask) == (flow_off_char_q & char_mask));
  assign addr_match = rx_char_valid &&
                      ((rx_char & char_mask) == (wake_address_char_q & char_mask));

  // ------------------------------
  // Status word
  // ------------------------------
  always @* begin
    case (txf_state_q)
      TXF_NORM: txf_code = `UFC_TXF_NORMAL;
      TXF_PEND: txf_code = `UFC_TXF_PENDING;
      TXF_REEN: txf_code = `UFC_TXF_REENABLED;
      TXF_HALT: txf_code = `UFC_TXF_HALTED;
      default:  txf_code = `UFC_TXF_NORMAL;
    endcase
  end

  assign any_auto    = auto_tx_q || auto_rx_q;
  assign status_word = {rx_field_q,
                        auto_rx_q ? atx_field_q : 2'b00,
                        txf_code,
                        any_auto ? txc_field_q : `UFC_TXC_DATA};
  assign tx_halt     = txf_state_q[3];

  // Read data mux; the write-only recognition enable reads zero
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `UFC_OFS_FREE_COUNT: rd_mux[7:0] = free_full[7:0];
      `UFC_OFS_ON_CHAR:    rd_mux[7:0] = flow_on_char_q;
      `UFC_OFS_OFF_CHAR:   rd_mux[7:0] = flow_off_char_q;
      `UFC_OFS_WAKE_CHAR:  rd_mux[7:0] = wake_address_char_q;
      `UFC_OFS_STATUS:     rd_mux[7:0] = status_word;
      `UFC_OFS_CTRL:       rd_mux[3:0] = {flow_mask_q, wd_en_q, auto_rx_q, auto_tx_q};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data latch; also keeps the status snapshot that the read clears
  always @(posedge ref_clk) begin
    if (!nrst) begin
      prdata      <= 32'h0000_0000;
      rd_status_q <= 8'h00;
    end else if (setup_ph) begin
      prdata      <= rd_mux;
      rd_status_q <= status_word;
    end
  end

  // ------------------------------
  // Compare character and control registers
  // ------------------------------
  // Both action bits set resolves to disable by testing disable first
  always @(posedge ref_clk) begin
    if (!nrst) begin
      flow_on_char_q      <= `UFC_RST_ON_CHAR;
      flow_off_char_q     <= `UFC_RST_OFF_CHAR;
      wake_address_char_q <= `UFC_RST_WAKE_CHAR;
      rec_on_en_q         <= 1'b0;
      rec_off_en_q        <= 1'b0;
      rec_addr_en_q       <= 1'b0;
      wd_en_q             <= 1'b0;
      auto_tx_q           <= 1'b0;
      auto_rx_q           <= 1'b0;
      flow_mask_q         <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        `UFC_OFS_ON_CHAR:   flow_on_char_q      <= pwdata[7:0];
        `UFC_OFS_OFF_CHAR:  flow_off_char_q     <= pwdata[7:0];
        `UFC_OFS_WAKE_CHAR: wake_address_char_q <= pwdata[7:0];
        `UFC_OFS_RECOG_EN: begin
          if (pwdata[`UFC_RE_WD_DIS])
            wd_en_q <= 1'b0;
          else if (pwdata[`UFC_RE_WD_EN])
            wd_en_q <= 1'b1;
          if (pwdata[`UFC_RE_ADDR_DIS])
            rec_addr_en_q <= 1'b0;
          else if (pwdata[`UFC_RE_ADDR_EN])
            rec_addr_en_q <= 1'b1;
          if (pwdata[`UFC_RE_ON_DIS])
            rec_on_en_q <= 1'b0;
          else if (pwdata[`UFC_RE_ON_EN])
            rec_on_en_q <= 1'b1;
          if (pwdata[`UFC_RE_OFF_DIS])
            rec_off_en_q <= 1'b0;
          else if (pwdata[`UFC_RE_OFF_EN])
            rec_off_en_q <= 1'b1;
        end
        `UFC_OFS_CTRL: begin
          auto_tx_q   <= pwdata[`UFC_CTL_AUTO_TX];
          auto_rx_q   <= pwdata[`UFC_CTL_AUTO_RX];
          wd_en_q     <= pwdata[`UFC_CTL_WD_EN];
          flow_mask_q <= pwdata[`UFC_CTL_FLOW_MASK];
        end
        default: ;
      endcase
    end
  end

  // ------------------------------
  // Recognition events
  // ------------------------------
  // Register-enabled recognition only reports; flow actions stay separate
  always @(posedge ref_clk) begin
    if (!nrst) begin
      on_char_event   <= 1'b0;
      off_char_event  <= 1'b0;
      wake_addr_event <= 1'b0;
      flow_irq_event  <= 1'b0;
    end else begin
      on_char_event   <= on_match && rec_on_en_q;
      off_char_event  <= off_match && rec_off_en_q;
      wake_addr_event <= addr_match && rec_addr_en_q;
      flow_irq_event  <= flow_mask_q && (on_match || off_match);
    end
  end

  // ------------------------------
  // Received and auto-transmitted fields
  // ------------------------------
  // A read clears only what it returned, so a new set is never lost
  always @(posedge ref_clk) begin
    if (!nrst) begin
      rx_field_q  <= 2'b00;
      atx_field_q <= 2'b00;
    end else begin
      rx_field_q <= (rx_field_q & ~({2{status_rd}} & rd_status_q[7:6]))
                    | {on_match, off_match};
      if (!auto_rx_q)
        atx_field_q <= 2'b00;
      else
        atx_field_q <= (atx_field_q & ~({2{status_rd}} & rd_status_q[5:4]))
                       | {flow_send_ack && off_sent_q == 1'b0 && flow_send_char == flow_off_char_q,
                          flow_send_ack && flow_send_char == flow_on_char_q};
    end
  end

  // ------------------------------
  // Transmitter flow state machine
  // ------------------------------
  always @* begin
    txf_state_d = txf_state_q;
    case (txf_state_q)
      TXF_NORM: if (auto_tx_q && off_match)
        txf_state_d = tx_busy ? TXF_PEND : TXF_HALT;
      TXF_PEND: if (tx_char_done || !tx_busy)
        txf_state_d = TXF_HALT;
      TXF_HALT: if (on_match)
        txf_state_d = TXF_REEN;
      TXF_REEN: begin
        if (auto_tx_q && off_match)
          txf_state_d = tx_busy ? TXF_PEND : TXF_HALT;
        else if (status_rd)
          txf_state_d = TXF_NORM;
      end
      default: txf_state_d = TXF_NORM;
    endcase
    if (!auto_tx_q)
      txf_state_d = TXF_NORM;
  end

  always @(posedge ref_clk) begin
    if (!nrst)
      txf_state_q <= TXF_NORM;
    else
      txf_state_q <= txf_state_d;
  end

  // ------------------------------
  // Automatic receiver flow characters
  // ------------------------------
  // Flow chars go ahead of queued data, so the ack comes within a character time
  always @(posedge ref_clk) begin
    if (!nrst) begin
      flow_send_req  <= 1'b0;
      flow_send_char <= 8'h00;
      off_sent_q     <= 1'b0;
      sending_flow_q <= 1'b0;
      txc_field_q    <= `UFC_TXC_DATA;
    end else if (!auto_rx_q) begin
      flow_send_req  <= 1'b0;
      off_sent_q     <= 1'b0;
      sending_flow_q <= 1'b0;
      txc_field_q    <= `UFC_TXC_DATA;
    end else if (flow_send_req) begin
      if (flow_send_ack) begin
        flow_send_req  <= 1'b0;
        sending_flow_q <= 1'b1;
        off_sent_q     <= (flow_send_char == flow_off_char_q);
        txc_field_q    <= `UFC_TXC_DATA;
      end
    end else if (sending_flow_q) begin
      if (tx_char_done) begin
        sending_flow_q <= 1'b0;
        txc_field_q    <= `UFC_TXC_WAIT;
      end
    end else if (rx_fill_high && !off_sent_q) begin
      flow_send_req  <= 1'b1;
      flow_send_char <= flow_off_char_q;
      txc_field_q    <= `UFC_TXC_OFF_PEND;
    end else if (rx_fill_low && off_sent_q) begin
      flow_send_req  <= 1'b1;
      flow_send_char <= flow_on_char_q;
      txc_field_q    <= `UFC_TXC_ON_PEND;
    end else if (txc_field_q == `UFC_TXC_WAIT && bit_tick && tx_queue_count != 9'd0) begin
      txc_field_q <= `UFC_TXC_DATA;
    end
  end

  // ------------------------------
  // Receiver idle watchdog
  // ------------------------------
  ufc_watchdog u_watchdog (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .enable   (wd_en_q),
    .bit_tick (bit_tick),
    .rx_idle  (rx_idle),
    .timeout  (watchdog_event)
  );

endmodule

`default_nettype wire

//--- rtl/ufc_defines.vh
// Offsets, field positions, reset values and timing counts of the flow character block
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH

// ------------------------------
// Register byte offsets
// ------------------------------
`define UFC_OFS_FREE_COUNT   8'h00
`define UFC_OFS_ON_CHAR      8'h04
`define UFC_OFS_OFF_CHAR     8'h08
`define UFC_OFS_WAKE_CHAR    8'h0C
`define UFC_OFS_STATUS       8'h10
`define UFC_OFS_RECOG_EN     8'h14
`define UFC_OFS_CTRL         8'h18

// ------------------------------
// Reset values
// ------------------------------
`define UFC_RST_ON_CHAR      8'h11
`define UFC_RST_OFF_CHAR     8'h13
`define UFC_RST_WAKE_CHAR    8'h00

// ----------------------------------------------------------------
// Recognition enable action bits
// ----------------------------------------------------------------
`define UFC_RE_WD_DIS        7
`define UFC_RE_WD_EN         6
`define UFC_RE_ADDR_DIS      5
`define UFC_RE_ADDR_EN       4
`define UFC_RE_ON_DIS        3
`define UFC_RE_ON_EN         2
`define UFC_RE_OFF_DIS       1
`define UFC_RE_OFF_EN        0

// ----------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------
`define UFC_CTL_AUTO_TX      0
`define UFC_CTL_AUTO_RX      1
`define UFC_CTL_WD_EN        2
`define UFC_CTL_FLOW_MASK    3

// ----------------------------------------------------------------
// Field codes of the flow character status register
// ----------------------------------------------------------------
`define UFC_RXF_OFF_BIT      6
`define UFC_RXF_ON_BIT       7
`define UFC_ATX_ON_BIT       4
`define UFC_ATX_OFF_BIT      5
`define UFC_TXF_NORMAL       2'b00
`define UFC_TXF_PENDING      2'b01
`define UFC_TXF_REENABLED    2'b10
`define UFC_TXF_HALTED       2'b11
`define UFC_TXC_DATA         2'b00
`define UFC_TXC_WAIT         2'b01
`define UFC_TXC_OFF_PEND     2'b10
`define UFC_TXC_ON_PEND      2'b11

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define UFC_WD_IDLE_BITS     7'd64
`define UFC_QUEUE_DEPTH      9'd256

`endif

//--- rtl/ufc_watchdog.v
// Receiver idle watchdog counting idle bit times
`timescale 1ns/10ps
`default_nettype none

`include "ufc_defines.vh"

module ufc_watchdog (
  input  wire       ref_clk,
  input  wire       nrst,
  input  wire       enable,
  input  wire       bit_tick,
  input  wire       rx_idle,
  output reg        timeout
);

  reg  [6:0] idle_cnt_q;
  reg        fired_q;

  // ------------------------------
  // Idle counter
  // ------------------------------
  // Counts bit times while the line idles; fires once, then waits for activity
  always @(posedge ref_clk) begin
    if (!nrst) begin
      idle_cnt_q <= 7'd0;
      fired_q    <= 1'b0;
      timeout    <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (!enable || !rx_idle) begin
        idle_cnt_q <= 7'd0;
        fired_q    <= 1'b0;
      end else if (bit_tick && !fired_q) begin
        if (idle_cnt_q == `UFC_WD_IDLE_BITS - 7'd1) begin
          timeout    <= 1'b1;
          fired_q    <= 1'b1;
          idle_cnt_q <= 7'd0;
        end else begin
          idle_cnt_q <= idle_cnt_q + 7'd1;
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- tb/ufc_flow_char_props.sv
// Port-level assertions for the flow character block
`timescale 1ns/10ps
`default_nettype none
module ufc_flow_char_props (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       rx_char_valid,
  input wire logic       rx_fill_high,
  input wire logic       rx_fill_low,
  input wire logic [8:0] tx_queue_count,
  input wire logic       flow_send_ack,
  input wire logic       flow_send_req,
  input wire logic [7:0] flow_send_char,
  input wire logic       transmit_ready_flag,
  input wire logic       off_char_event,
  input wire logic       rx_idle,
  input wire logic       watchdog_event
);
  // ------------------------------
  // Checks, all in one clock domain
  // ------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_ready_const: assert property (pready)
    else $error("pready dropped");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
    else $error("missing slverr");
  a_ready_level: assert property (
    transmit_ready_flag == (tx_queue_count != 9'h100))
    else $error("ready flag wrong");
  // Request and char stand until taken
  a_req_hold: assert property (
    flow_send_req && !flow_send_ack |=> flow_send_req && $stable(flow_send_char))
    else $error("request not held");
  a_req_drop: assert property (flow_send_req && flow_send_ack |=> !flow_send_req)
    else $error("request kept after ack");
  a_req_cause: assert property (
    $rose(flow_send_req) |-> $past(rx_fill_high || rx_fill_low))
    else $error("request without cause");
  a_off_cause: assert property (off_char_event |-> $past(rx_char_valid))
    else $error("event without char");
  a_wd_idle: assert property (
    watchdog_event |-> $past(rx_idle) && !$past(watchdog_event))
    else $error("bad watchdog pulse");
  cover property (flow_send_req ##[1:20] flow_send_ack);
  cover property (off_char_event);
  cover property (watchdog_event);
endmodule
`default_nettype wire

//--- tb/ufc_remote_station.sv
// Remote station model: bit clock, receive line and flow character transmitter
`timescale 1ns/10ps
`default_nettype none
module ufc_remote_station (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [3:0] ack_delay,
  input  wire logic       inject,
  input  wire logic [7:0] inject_char,
  input  wire logic       line_busy,
  input  wire logic       flow_send_req,
  input  wire logic [7:0] flow_send_char,
  output var  logic       bit_tick,
  output var  logic       rx_idle,
  output var  logic       rx_char_valid,
  output var  logic [7:0] rx_char,
  output var  logic       tx_busy,
  output var  logic       tx_char_done,
  output var  logic       flow_send_ack,
  output var  logic [7:0] sent_char,
  output var  logic [7:0] sent_n
);
  logic [3:0] tick_q;
  logic [3:0] wait_q;
  logic [3:0] busy_q;
  // One bit time per 16 clocks; ack may be prompt or slow
  always @(posedge ref_clk) begin
    tick_q        <= tick_q + 4'h1;
    bit_tick      <= (tick_q == 4'hF);
    rx_idle       <= !line_busy && !inject;
    rx_char_valid <= inject;
    rx_char       <= inject ? inject_char : ~rx_char;  // Between frames the last char is inverted every clock
    flow_send_ack <= 1'b0;
    tx_char_done  <= 1'b0;
    if (!nrst) begin
      tick_q  <= 4'h0;
      wait_q  <= 4'h0;
      busy_q  <= 4'h0;
      tx_busy <= 1'b0;
      sent_n  <= 8'h00;
      rx_char <= 8'h00;
    end else if (busy_q != 4'h0) begin
      busy_q       <= busy_q - 4'h1;
      tx_busy      <= (busy_q != 4'h1);
      tx_char_done <= (busy_q == 4'h1);
    end else if (flow_send_req && !flow_send_ack) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q == ack_delay) begin
        flow_send_ack <= 1'b1;
        wait_q        <= 4'h0;
        busy_q        <= 4'hA;
        tx_busy       <= 1'b1;
        sent_char     <= flow_send_char;
        sent_n        <= sent_n + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/uart_flow_char_recognition_tb_top.sv
// Self-checking bench for the flow character block
`timescale 1ns/10ps
`default_nettype none
`include "ufc_defines.vh"
module uart_flow_char_recognition_tb_top;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, bit_tick, rx_idle, rx_char_valid, tx_busy, tx_char_done;
  logic        flow_send_ack, flow_send_req, tx_halt, transmit_ready_flag, watchdog_event;
  logic        on_char_event, off_char_event, wake_addr_event, flow_irq_event;
  logic [7:0]  rx_char, flow_send_char, sent_char, sent_n, n0;
  logic [1:0]  char_len = 2'd3;
  logic        rx_fill_high = 1'b0, rx_fill_low = 1'b0, line_busy = 1'b0, inject = 1'b0;
  logic [7:0]  inject_char = 8'h00;
  logic [3:0]  ack_delay = 4'hF;
  logic [8:0]  tx_queue_count = 9'h000, q;
  logic [15:0] rnd = 16'h1C00;
  logic [65:0] notes[$];
  logic [65:0] note;
  int          n_errors = 0;
  int          comparisons = 0;
  int          off_n = 0, on_n = 0, wk_n = 0, irq_n = 0, wd_n = 0;
  int          cnt_tab[4] = '{0, 1, 255, 256};
  // 200 MHz reference clock
  always #2.5 ref_clk = ~ref_clk;
  ufc_flow_char dut_u (
    .ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .bit_tick, .rx_idle, .rx_char_valid, .rx_char, .char_len, .rx_fill_high, .rx_fill_low,
    .tx_queue_count, .tx_busy, .tx_char_done, .flow_send_ack, .flow_send_req,
    .flow_send_char, .tx_halt, .transmit_ready_flag, .on_char_event, .off_char_event,
    .wake_addr_event, .flow_irq_event, .watchdog_event);
  ufc_remote_station stn_u (
    .ref_clk, .nrst, .ack_delay, .inject, .inject_char, .line_busy, .flow_send_req,
    .flow_send_char, .bit_tick, .rx_idle, .rx_char_valid, .rx_char, .tx_busy,
    .tx_char_done, .flow_send_ack, .sent_char, .sent_n);
  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [32:0] ev();
    ev = 33'(irq_n * 4096 + wk_n * 256 + on_n * 16 + off_n);
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Note the expectation, then run one transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    notes.push_back({m, e & m});
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0_0000_0000, 33'h1_0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, a, 32'h0000_0000, {25'h000_0000, e}, {1'b1, 24'hFF_FFFF, m});
  endtask
  task automatic send(input logic [7:0] c);
    @(posedge ref_clk);
    inject      <= 1'b1;
    inject_char <= c;
    @(posedge ref_clk);
    inject <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // Line activity restarts the idle count
  task automatic idle_run();
    line_busy <= 1'b1;
    repeat (2) @(posedge ref_clk);
    line_busy <= 1'b0;
    repeat (1200) @(posedge ref_clk);
  endtask
  task automatic wait_sent();
    for (int k = 0; k < 100 && sent_n == n0; k++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Count events; retire one note per access
  always @(posedge ref_clk) begin
    off_n <= off_n + (off_char_event === 1'b1);
    on_n  <= on_n + (on_char_event === 1'b1);
    wk_n  <= wk_n + (wake_addr_event === 1'b1);
    irq_n <= irq_n + (flow_irq_event === 1'b1);
    wd_n  <= wd_n + (watchdog_event === 1'b1);
    if (psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      check({pslverr, prdata} & note[65:33], note[32:0]);
    end
  end
  // Hang limit, about three times the run length
  initial begin
    repeat (12000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(`UFC_OFS_ON_CHAR, `UFC_RST_ON_CHAR, 8'hFF);
    rd(`UFC_OFS_OFF_CHAR, `UFC_RST_OFF_CHAR, 8'hFF);
    rd(`UFC_OFS_WAKE_CHAR, `UFC_RST_WAKE_CHAR, 8'hFF);
    rd(`UFC_OFS_RECOG_EN, 8'h00, 8'hFF);
    apb(1'b0, 8'h1C, 32'h0000_0000, 33'h1_0000_0000, 33'h1_0000_0000);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wr(`UFC_OFS_ON_CHAR + 8'(4 * i), {24'h00_0000, rnd[7:0]});
      rd(`UFC_OFS_ON_CHAR + 8'(4 * i), rnd[7:0], 8'hFF);
    end
    wr(`UFC_OFS_ON_CHAR, 32'h0000_0011);
    wr(`UFC_OFS_OFF_CHAR, 32'h0000_0013);
    wr(`UFC_OFS_WAKE_CHAR, 32'h0000_005A);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      q = (i < 4) ? 9'(cnt_tab[i]) : {1'b0, rnd[7:0]};
      tx_queue_count <= q;
      rd(`UFC_OFS_FREE_COUNT, 8'(9'h100 - q), 8'hFF);
      check(33'(transmit_ready_flag), 33'(q != 9'h100));
    end
    tx_queue_count <= 9'h000;  // Empty queue keeps the wait code up
    $display("test free count done");
    send(8'h13);
    rd(`UFC_OFS_STATUS, 8'h40, 8'hC0);
    send(8'h13);
    send(8'h11);
    rd(`UFC_OFS_STATUS, 8'hC0, 8'hC0);
    rd(`UFC_OFS_STATUS, 8'h00, 8'hF3);
    char_len <= 2'd0;
    send(8'hF3);
    rd(`UFC_OFS_STATUS, 8'h40, 8'hC0);
    char_len <= 2'd3;
    check(ev(), 33'h0);
    $display("test detection done");
    wr(`UFC_OFS_RECOG_EN, 32'h0000_0015);
    send(8'h13);
    send(8'h11);
    send(8'h5A);
    check(ev(), 33'h111);
    check(33'(flow_send_req), 33'h0);
    wr(`UFC_OFS_RECOG_EN, 32'h0000_003F);
    send(8'h13);
    send(8'h11);
    send(8'h5A);
    check(ev(), 33'h111);
    wr(`UFC_OFS_CTRL, 32'h0000_0008);
    send(8'h13);
    check(ev(), 33'h1111);
    rd(`UFC_OFS_STATUS, 8'h00, 8'h00);
    $display("test recognition done");
    wr(`UFC_OFS_CTRL, 32'h0000_0002);
    n0 = sent_n;
    rx_fill_high <= 1'b1;
    for (int k = 0; k < 50 && flow_send_req !== 1'b1; k++) @(posedge ref_clk);
    rd(`UFC_OFS_STATUS, 8'h02, 8'h03);
    wait_sent();
    check(33'(sent_char), 33'h13);
    rx_fill_high <= 1'b0;
    rd(`UFC_OFS_STATUS, 8'h20, 8'h30);
    ack_delay <= 4'h0;
    n0 = sent_n;
    rx_fill_low <= 1'b1;
    wait_sent();
    check(33'(sent_char), 33'h11);
    rx_fill_low <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rd(`UFC_OFS_STATUS, 8'h11, 8'h33);
    // Last automatic char was Xon, so the host owes the remote nothing
    wr(`UFC_OFS_CTRL, 32'h0000_0000);
    rd(`UFC_OFS_STATUS, 8'h00, 8'h33);
    $display("test auto receive flow done");
    wr(`UFC_OFS_CTRL, 32'h0000_0001);
    send(8'h13);
    check(33'(tx_halt), 33'h1);
    rd(`UFC_OFS_STATUS, 8'h0C, 8'h0C);
    send(8'h11);
    rd(`UFC_OFS_STATUS, 8'h08, 8'h0C);
    rd(`UFC_OFS_STATUS, 8'h00, 8'h0C);
    check(33'(tx_halt), 33'h0);
    wr(`UFC_OFS_CTRL, 32'h0000_0000);
    $display("test auto transmit flow done");
    wr(`UFC_OFS_RECOG_EN, 32'h0000_0040);
    idle_run();
    check(33'(wd_n), 33'h1);
    wr(`UFC_OFS_RECOG_EN, 32'h0000_0080);
    idle_run();
    check(33'(wd_n), 33'h1);
    wr(`UFC_OFS_CTRL, 32'h0000_0004);
    idle_run();
    check(33'(wd_n), 33'h2);
    $display("test watchdog done");
    tally_and_finish();
  end
endmodule
bind ufc_flow_char ufc_flow_char_props ufc_props_u (
  .ref_clk, .nrst, .psel, .penable, .paddr, .pready, .pslverr, .rx_char_valid,
  .rx_fill_high, .rx_fill_low, .tx_queue_count, .flow_send_ack, .flow_send_req,
  .flow_send_char, .transmit_ready_flag, .off_char_event, .rx_idle, .watchdog_event);
`default_nettype wire
